// ---- core/pfcc_defs.svh ----
// constants for the parallel flash command controller
`ifndef PFCC_DEFS_SVH
`define PFCC_DEFS_SVH

// ------------------------------------------------------------
// clock and time conversion
// ------------------------------------------------------------
`define PFCC_CLK_MHZ 100
`define PFCC_NS2CYC(ns) (((ns) * `PFCC_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------
// bus cycle timing
// ------------------------------------------------------------
`define PFCC_SETUP_NS 10
`define PFCC_WR_STROBE_NS 50
`define PFCC_RD_ACCESS_NS 70
`define PFCC_HOLD_NS 20
`define PFCC_SETUP_CYC `PFCC_NS2CYC(`PFCC_SETUP_NS)
`define PFCC_WR_STROBE_CYC `PFCC_NS2CYC(`PFCC_WR_STROBE_NS)
`define PFCC_RD_ACCESS_CYC `PFCC_NS2CYC(`PFCC_RD_ACCESS_NS)
`define PFCC_HOLD_CYC `PFCC_NS2CYC(`PFCC_HOLD_NS)

// ------------------------------------------------------------
// operation timing
// ------------------------------------------------------------
`define PFCC_BYTE_PROG_US 50
`define PFCC_CHIP_ERASE_MS 20000
`define PFCC_RESET_LOW_NS 500
`define PFCC_RESET_RECOVER_NS 1000
`define PFCC_RESET_LOW_CYC `PFCC_NS2CYC(`PFCC_RESET_LOW_NS)
`define PFCC_RESET_RECOVER_CYC `PFCC_NS2CYC(`PFCC_RESET_RECOVER_NS)

// ------------------------------------------------------------
// command addresses and codes
// ------------------------------------------------------------
`define PFCC_UNLOCK_ADDR1 17'h05555
`define PFCC_UNLOCK_ADDR2 17'h02aaa
`define PFCC_UNLOCK_DATA1 8'haa
`define PFCC_UNLOCK_DATA2 8'h55
`define PFCC_CODE_ERASE_SETUP 8'h80
`define PFCC_CODE_PROGRAM 8'ha0
`define PFCC_CODE_ID_ENTRY 8'h90
`define PFCC_CODE_ID_EXIT 8'hf0
`define PFCC_CODE_CHIP_ERASE 8'h10
`define PFCC_CODE_SECTOR_ERASE 8'h30
`define PFCC_CODE_LOCKOUT 8'h40
`define PFCC_LOCK_ADDR_BOTTOM 17'h00002
`define PFCC_LOCK_ADDR_TOP 17'h1c002

`endif

// ---- core/pfcc_pkg.sv ----
// types shared by the parallel flash command controller
package pfcc_pkg;

	typedef enum logic [3:0] {
		OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_LOCKOUT,
		OP_ID_ENTRY, OP_ID_EXIT, OP_LOCK_QUERY, OP_RESET
	} pfcc_op_t;

	typedef enum logic [1:0] {SEC_BOOT, SEC_PARAM, SEC_MAIN1, SEC_MAIN2} pfcc_sector_t;

	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} pfcc_bc_state_t;

	typedef enum logic [2:0] {
		M_RESET, M_RECOVER, M_IDLE, M_STEP, M_WAIT, M_POLL, M_POLL_WAIT, M_RESP
	} pfcc_main_state_t;

	typedef struct packed {
		pfcc_op_t op;
		logic override;
		logic [16:0] addr;
		logic [7:0] data;
	} pfcc_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic err;
		logic warn;
		logic locked;
	} pfcc_rsp_t;

	typedef struct packed {
		logic [16:0] addr;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [7:0] dq;
		logic dq_oe;
	} pfcc_bus_t;

	typedef struct packed {
		logic wr;
		logic [16:0] addr;
		logic [7:0] data;
	} pfcc_step_t;

endpackage

// ---- core/pfcc_bus_cycle.sv ----
// one read or write cycle on the flash pins
`timescale 1ns/1ns
`include "pfcc_defs.svh"
module pfcc_bus_cycle
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // sync reset
	input wire logic en_i, // clock enable
	input wire logic start_i, // begin a cycle
	input wire pfcc_pkg::pfcc_step_t step_i, // kind, address, data
	output logic ready_o, // idle, may start
	output logic done_o, // cycle finished
	output logic [7:0] rdata_o, // byte read
	input wire logic [7:0] dq_i, // data pins in
	output pfcc_pkg::pfcc_bus_t bus_o // pin outputs
);

	typedef struct packed {
		pfcc_pkg::pfcc_bc_state_t st;
		logic wr;
		logic [3:0] cnt;
		logic done;
		logic [7:0] rdata;
		pfcc_pkg::pfcc_bus_t bus;
	} pfcc_bc_reg_t;

	localparam pfcc_bc_reg_t BC_RESET = '{st: pfcc_pkg::BC_IDLE, wr: 1'b0, cnt: 4'h0, done: 1'b0,
		rdata: 8'h00, bus: '{addr: 17'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq: 8'h00, dq_oe: 1'b0}};

	pfcc_bc_reg_t s_q;
	pfcc_bc_reg_t s_d;

	// ------------------------------------------------------------
	// cycle sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			pfcc_pkg::BC_IDLE:
			begin
				if (start_i)
				begin
					s_d.wr = step_i.wr;
					s_d.bus.addr = step_i.addr;
					s_d.bus.dq = step_i.data;
					// oe stays high, so driving data early cannot fight the flash
					s_d.bus.dq_oe = step_i.wr;
					s_d.bus.ce_n = 1'b0;
					s_d.cnt = 4'(`PFCC_SETUP_CYC);
					s_d.st = pfcc_pkg::BC_SETUP;
				end
			end
			pfcc_pkg::BC_SETUP:
			begin
				if (s_q.cnt > 4'h1)
				begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
				else
				begin
					s_d.bus.we_n = ~s_q.wr;
					s_d.bus.oe_n = s_q.wr;
					s_d.cnt = s_q.wr ? 4'(`PFCC_WR_STROBE_CYC) : 4'(`PFCC_RD_ACCESS_CYC);
					s_d.st = pfcc_pkg::BC_STROBE;
				end
			end
			pfcc_pkg::BC_STROBE:
			begin
				if (s_q.cnt > 4'h1)
				begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
				else
				begin
					if (!s_q.wr)
					begin
						s_d.rdata = dq_i;
					end
					s_d.bus.we_n = 1'b1;
					s_d.bus.oe_n = 1'b1;
					s_d.bus.ce_n = 1'b1;
					s_d.cnt = 4'(`PFCC_HOLD_CYC);
					s_d.st = pfcc_pkg::BC_HOLD;
				end
			end
			pfcc_pkg::BC_HOLD:
			begin
				if (s_q.cnt > 4'h1)
				begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
				else
				begin
					s_d.bus.dq_oe = 1'b0;
					s_d.done = 1'b1;
					s_d.st = pfcc_pkg::BC_IDLE;
				end
			end
			default:
			begin
				s_d = BC_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= BC_RESET;
		end
		else if (en_i)
		begin
			s_q <= s_d;
		end
	end

	assign ready_o = (s_q.st == pfcc_pkg::BC_IDLE);
	assign done_o = s_q.done;
	assign rdata_o = s_q.rdata;
	assign bus_o = s_q.bus;

endmodule // pfcc_bus_cycle

// ---- core/pfcc_ctrl.sv ----
// command controller driving a parallel flash through its pins
`timescale 1ns/1ns
`include "pfcc_defs.svh"
module pfcc_ctrl
#(
	parameter int unsigned BP_TIMEOUT_CYC = `PFCC_BYTE_PROG_US * `PFCC_CLK_MHZ,
	parameter int unsigned ERASE_TIMEOUT_CYC = `PFCC_CHIP_ERASE_MS * 1000 * `PFCC_CLK_MHZ,
	parameter bit TOP_BOOT = 1'b0,
	parameter bit HAS_RESET_PIN = 1'b1
)
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // sync reset
	input wire logic en_i, // clock enable
	input wire logic cmd_valid_i, // command offered
	output logic cmd_ready_o, // command taken when valid
	input wire pfcc_pkg::pfcc_cmd_t cmd_i, // operation, address, data
	output logic rsp_valid_o, // one-cycle answer
	output pfcc_pkg::pfcc_rsp_t rsp_o, // answer contents
	output logic [16:0] flash_addr_o, // address pins
	output logic flash_ce_n_o, // chip select
	output logic flash_oe_n_o, // output enable
	output logic flash_we_n_o, // write strobe
	output logic [7:0] flash_dq_o, // data pins out
	output logic flash_dq_oe_o, // data pins driven
	input wire logic [7:0] flash_dq_i, // data pins in
	output logic flash_rst_n_o, // flash reset pin
	output logic hv_override_o // asks for high voltage on reset pin
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// boot block placement
	function automatic pfcc_pkg::pfcc_sector_t sector_of(input logic [16:0] a);
		pfcc_pkg::pfcc_sector_t k;
		k = pfcc_pkg::SEC_MAIN2;
		if (TOP_BOOT)
		begin
			if (a[16:14] == 3'h7)
				k = pfcc_pkg::SEC_BOOT;
			else if (a[16:14] == 3'h6)
				k = pfcc_pkg::SEC_PARAM;
			else if (a[16:15] == 2'h2)
				k = pfcc_pkg::SEC_MAIN1;
		end
		else
		begin
			if (a[16:14] == 3'h0)
				k = pfcc_pkg::SEC_BOOT;
			else if (a[16:14] == 3'h1)
				k = pfcc_pkg::SEC_PARAM;
			else if (a[16:15] == 2'h1)
				k = pfcc_pkg::SEC_MAIN1;
		end
		return k;
	endfunction

	function automatic logic [2:0] seq_len(input pfcc_pkg::pfcc_op_t op);
		logic [2:0] n;
		case (op)
			pfcc_pkg::OP_READ: n = 3'h1;
			pfcc_pkg::OP_ID_EXIT: n = 3'h1;
			pfcc_pkg::OP_PROGRAM: n = 3'h4;
			pfcc_pkg::OP_ID_ENTRY: n = 3'h3;
			pfcc_pkg::OP_LOCK_QUERY: n = 3'h5;
			default: n = 3'h6;
		endcase
		return n;
	endfunction

	function automatic pfcc_pkg::pfcc_step_t seq_step(input pfcc_pkg::pfcc_cmd_t c, input logic [2:0] i);
		pfcc_pkg::pfcc_step_t s;
		s = '{wr: 1'b1, addr: `PFCC_UNLOCK_ADDR1, data: `PFCC_UNLOCK_DATA1};
		if (i == 3'h1 || i == 3'h4)
			s = '{wr: 1'b1, addr: `PFCC_UNLOCK_ADDR2, data: `PFCC_UNLOCK_DATA2};
		if (i == 3'h2)
		begin
			case (c.op)
				pfcc_pkg::OP_PROGRAM: s.data = `PFCC_CODE_PROGRAM;
				pfcc_pkg::OP_ID_ENTRY: s.data = `PFCC_CODE_ID_ENTRY;
				pfcc_pkg::OP_LOCK_QUERY: s.data = `PFCC_CODE_ID_ENTRY;
				default: s.data = `PFCC_CODE_ERASE_SETUP;
			endcase
		end
		if (c.op == pfcc_pkg::OP_READ)
			s = '{wr: 1'b0, addr: c.addr, data: 8'h00};
		// single-cycle exit, any address
		if (c.op == pfcc_pkg::OP_ID_EXIT)
			s = '{wr: 1'b1, addr: 17'h00000, data: `PFCC_CODE_ID_EXIT};
		if (c.op == pfcc_pkg::OP_PROGRAM && i == 3'h3)
			s = '{wr: 1'b1, addr: c.addr, data: c.data};
		if (c.op == pfcc_pkg::OP_LOCK_QUERY && i == 3'h3)
			s = '{wr: 1'b0, addr: TOP_BOOT ? `PFCC_LOCK_ADDR_TOP : `PFCC_LOCK_ADDR_BOTTOM, data: 8'h00};
		if (c.op == pfcc_pkg::OP_LOCK_QUERY && i == 3'h4)
			s = '{wr: 1'b1, addr: 17'h00000, data: `PFCC_CODE_ID_EXIT};
		if (i == 3'h5)
		begin
			case (c.op)
				pfcc_pkg::OP_SECTOR_ERASE: s = '{wr: 1'b1, addr: c.addr, data: `PFCC_CODE_SECTOR_ERASE};
				pfcc_pkg::OP_LOCKOUT: s.data = `PFCC_CODE_LOCKOUT;
				default: s.data = `PFCC_CODE_CHIP_ERASE;
			endcase
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pfcc_pkg::pfcc_main_state_t st;
		pfcc_pkg::pfcc_cmd_t cmd;
		logic [2:0] idx;
		logic [31:0] timer;
		logic prev_toggle;
		logic have_prev;
		logic lock_known;
		logic locked;
		logic last_main_valid;
		pfcc_pkg::pfcc_sector_t last_main;
		logic rst_n;
		logic hv;
		logic rsp_valid;
		pfcc_pkg::pfcc_rsp_t rsp;
	} pfcc_main_reg_t;

	// reset starts with the flash reset pin low, giving it a clean start
	localparam pfcc_main_reg_t M_RESET_VAL = '{st: pfcc_pkg::M_RESET,
		cmd: '{op: pfcc_pkg::OP_READ, override: 1'b0, addr: 17'h00000, data: 8'h00},
		idx: 3'h0, timer: 32'(`PFCC_RESET_LOW_CYC), prev_toggle: 1'b0, have_prev: 1'b0,
		lock_known: 1'b0, locked: 1'b0, last_main_valid: 1'b0, last_main: pfcc_pkg::SEC_MAIN1,
		rst_n: 1'b0, hv: 1'b0, rsp_valid: 1'b0, rsp: '{data: 8'h00, err: 1'b0, warn: 1'b0, locked: 1'b0}};

	pfcc_main_reg_t s_q;
	pfcc_main_reg_t s_d;

	logic bc_start;
	logic bc_ready;
	logic bc_done;
	logic [7:0] bc_rdata;
	pfcc_pkg::pfcc_step_t bc_step;
	pfcc_pkg::pfcc_bus_t bus;
	pfcc_pkg::pfcc_sector_t cmd_sec;
	logic boot_refused;

	assign cmd_sec = sector_of(cmd_i.addr);
	assign boot_refused = s_q.locked && cmd_sec == pfcc_pkg::SEC_BOOT && !(cmd_i.override && HAS_RESET_PIN) &&
		(cmd_i.op == pfcc_pkg::OP_PROGRAM || cmd_i.op == pfcc_pkg::OP_SECTOR_ERASE);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		bc_start = 1'b0;
		bc_step = seq_step(s_q.cmd, s_q.idx);
		case (s_q.st)
			// reset pin low aborts flash operation
			pfcc_pkg::M_RESET:
			begin
				s_d.rst_n = 1'b0;
				s_d.timer = s_q.timer - 32'h1;
				if (s_q.timer <= 32'h1)
				begin
					s_d.rst_n = 1'b1;
					s_d.timer = 32'(`PFCC_RESET_RECOVER_CYC);
					s_d.st = pfcc_pkg::M_RECOVER;
				end
			end
			pfcc_pkg::M_RECOVER:
			begin
				s_d.timer = s_q.timer - 32'h1;
				if (s_q.timer <= 32'h1)
				begin
					s_d.st = (s_q.cmd.op == pfcc_pkg::OP_RESET) ? pfcc_pkg::M_RESP : pfcc_pkg::M_IDLE;
				end
			end
			pfcc_pkg::M_IDLE:
			begin
				if (cmd_valid_i)
				begin
					s_d.cmd = cmd_i;
					s_d.idx = 3'h0;
					s_d.rsp = '{data: 8'h00, err: 1'b0, warn: 1'b0, locked: s_q.locked};
					// same main block as the last main-block erase, even with boot or parameter erases between; a chip erase clears it
					s_d.rsp.warn = cmd_i.op == pfcc_pkg::OP_SECTOR_ERASE && s_q.last_main_valid &&
						cmd_sec == s_q.last_main;
					// override only with a reset pin
					s_d.hv = cmd_i.override && HAS_RESET_PIN;
					if (cmd_i.op == pfcc_pkg::OP_RESET)
					begin
						// pin drops at once, so the pulse lasts the full reset-low count
						s_d.rst_n = 1'b0;
						s_d.timer = 32'(`PFCC_RESET_LOW_CYC);
						s_d.st = pfcc_pkg::M_RESET;
					end
					else if (boot_refused)
					begin
						s_d.rsp.err = 1'b1;
						s_d.st = pfcc_pkg::M_RESP;
					end
					else
					begin
						s_d.st = pfcc_pkg::M_STEP;
					end
				end
			end
			pfcc_pkg::M_STEP:
			begin
				if (bc_ready)
				begin
					bc_start = 1'b1;
					s_d.st = pfcc_pkg::M_WAIT;
				end
			end
			pfcc_pkg::M_WAIT:
			begin
				if (bc_done)
				begin
					if (!bc_step.wr)
					begin
						s_d.rsp.data = bc_rdata;
					end
					if (s_q.cmd.op == pfcc_pkg::OP_LOCK_QUERY && !bc_step.wr)
					begin
						s_d.locked = bc_rdata[0];
						s_d.lock_known = 1'b1;
						s_d.rsp.locked = bc_rdata[0];
					end
					s_d.idx = s_q.idx + 3'h1;
					s_d.st = pfcc_pkg::M_STEP;
					if (s_q.idx == seq_len(s_q.cmd.op) - 3'h1)
					begin
						s_d.st = pfcc_pkg::M_RESP;
						s_d.have_prev = 1'b0;
						// program bounded by byte program time
						s_d.timer = (s_q.cmd.op == pfcc_pkg::OP_PROGRAM || s_q.cmd.op == pfcc_pkg::OP_LOCKOUT) ?
							32'(BP_TIMEOUT_CYC) : 32'(ERASE_TIMEOUT_CYC);
						case (s_q.cmd.op)
							pfcc_pkg::OP_PROGRAM, pfcc_pkg::OP_CHIP_ERASE, pfcc_pkg::OP_SECTOR_ERASE,
							pfcc_pkg::OP_LOCKOUT: s_d.st = pfcc_pkg::M_POLL;
							default: s_d.st = pfcc_pkg::M_RESP;
						endcase
					end
				end
			end
			pfcc_pkg::M_POLL, pfcc_pkg::M_POLL_WAIT:
			begin
				s_d.timer = s_q.timer - 32'h1;
				bc_step = '{wr: 1'b0, addr: s_q.cmd.addr, data: 8'h00};
				if (s_q.st == pfcc_pkg::M_POLL && bc_ready)
				begin
					bc_start = 1'b1;
					s_d.st = pfcc_pkg::M_POLL_WAIT;
				end
				if (s_q.st == pfcc_pkg::M_POLL_WAIT && bc_done)
				begin
					s_d.prev_toggle = bc_rdata[6];
					s_d.have_prev = 1'b1;
					s_d.st = pfcc_pkg::M_POLL;
					s_d.rsp.data = bc_rdata;
					if (s_q.cmd.op == pfcc_pkg::OP_PROGRAM && bc_rdata[7] == s_q.cmd.data[7])
					begin
						// any bit off the data, such as a zero that should be one, means not erased first
						s_d.rsp.err = (bc_rdata != s_q.cmd.data);
						s_d.st = pfcc_pkg::M_RESP;
					end
					if (s_q.cmd.op != pfcc_pkg::OP_PROGRAM && s_q.have_prev && bc_rdata[6] == s_q.prev_toggle)
					begin
						s_d.st = pfcc_pkg::M_RESP;
						if (s_q.cmd.op == pfcc_pkg::OP_LOCKOUT)
						begin
							s_d.locked = 1'b1;
							s_d.lock_known = 1'b1;
							s_d.rsp.locked = 1'b1;
						end
						if (s_q.cmd.op == pfcc_pkg::OP_CHIP_ERASE)
						begin
							s_d.last_main_valid = 1'b0;
						end
						if (s_q.cmd.op == pfcc_pkg::OP_SECTOR_ERASE && sector_of(s_q.cmd.addr) inside
							{pfcc_pkg::SEC_MAIN1, pfcc_pkg::SEC_MAIN2})
						begin
							s_d.last_main_valid = 1'b1;
							s_d.last_main = sector_of(s_q.cmd.addr);
						end
					end
				end
				// stuck flash: give up, the caller may reset and repeat
				if (s_q.timer == 32'h0)
				begin
					s_d.rsp.err = 1'b1;
					s_d.st = pfcc_pkg::M_RESP;
				end
			end
			pfcc_pkg::M_RESP:
			begin
				// wait for an open read to finish before answering
				if (bc_ready)
				begin
					s_d.rsp_valid = 1'b1;
					s_d.hv = 1'b0;
					s_d.st = pfcc_pkg::M_IDLE;
				end
			end
			default:
			begin
				s_d = M_RESET_VAL;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= M_RESET_VAL;
		end
		else if (en_i)
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// pin cycle engine
	// ------------------------------------------------------------
	pfcc_bus_cycle u_bus_cycle
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.en_i(en_i),
		.start_i(bc_start),
		.step_i(bc_step),
		.ready_o(bc_ready),
		.done_o(bc_done),
		.rdata_o(bc_rdata),
		.dq_i(flash_dq_i),
		.bus_o(bus)
	);

	assign cmd_ready_o = (s_q.st == pfcc_pkg::M_IDLE);
	assign rsp_valid_o = s_q.rsp_valid;
	assign rsp_o = s_q.rsp;
	assign flash_addr_o = bus.addr;
	assign flash_ce_n_o = bus.ce_n;
	assign flash_oe_n_o = bus.oe_n;
	assign flash_we_n_o = bus.we_n;
	assign flash_dq_o = bus.dq;
	assign flash_dq_oe_o = bus.dq_oe;
	assign flash_rst_n_o = s_q.rst_n;
	assign hv_override_o = s_q.hv;

endmodule // pfcc_ctrl

// ---- test/pfcc_ctrl_monitor.sv ----
// pin-level checks on the flash side of the command controller
`timescale 1ns/1ns
module pfcc_ctrl_monitor
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // sync reset
	input wire logic [16:0] flash_addr_o, // address pins
	input wire logic flash_ce_n_o, // chip select
	input wire logic flash_oe_n_o, // output enable
	input wire logic flash_we_n_o, // write strobe
	input wire logic [7:0] flash_dq_o, // data pins out
	input wire logic flash_dq_oe_o, // data pins driven
	input wire logic flash_rst_n_o // flash reset pin
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	a_read_clean:
	assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
		else $error("read strobe with bad companions");
	a_write_oe_high:
	assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o && flash_dq_oe_o)
		else $error("write strobe with bad companions");
	a_we_width:
	assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o)[*5] ##1 flash_we_n_o)
		else $error("write strobe width wrong");
	a_ce_before_we:
	assert property ($fell(flash_we_n_o) |-> !$past(flash_ce_n_o))
		else $error("chip select not low before strobe");
	a_addr_steady:
	assert property ($fell(flash_we_n_o) |-> ($stable(flash_addr_o) && $stable(flash_dq_o))[*5])
		else $error("address or data moved under strobe");
	a_data_at_rise:
	assert property ($rose(flash_we_n_o) |-> flash_dq_oe_o && $stable(flash_dq_o) && $stable(flash_addr_o))
		else $error("data not held at strobe rise");
	a_reset_quiet:
	assert property (!flash_rst_n_o |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o && !flash_dq_oe_o)
		else $error("pins active while flash in reset");
	a_rst_pulse:
	assert property ($fell(flash_rst_n_o) |-> ##49 !flash_rst_n_o ##1 flash_rst_n_o)
		else $error("flash reset pulse length wrong");
	a_rst_recover:
	assert property ($rose(flash_rst_n_o) |-> (flash_ce_n_o && flash_we_n_o)[*8])
		else $error("access too soon after flash reset");
endmodule // pfcc_ctrl_monitor

bind pfcc_ctrl pfcc_ctrl_monitor mon_u
(
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .flash_addr_o(flash_addr_o), .flash_ce_n_o(flash_ce_n_o),
	.flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o), .flash_dq_o(flash_dq_o),
	.flash_dq_oe_o(flash_dq_oe_o), .flash_rst_n_o(flash_rst_n_o)
);

// ---- test/pfcc_flash_model.sv ----
// behavioural bottom-boot parallel flash behind the controller
`timescale 1ns/1ns
module pfcc_flash_model
#(
	parameter int PROG_NS = 600,
	parameter int ERASE_NS = 3000
)
(
	input wire logic [16:0] addr_i, // address pins
	input wire logic ce_n_i, // chip select
	input wire logic oe_n_i, // output enable
	input wire logic we_n_i, // write strobe
	input wire logic [7:0] host_dq_i, // host data
	input wire logic host_oe_i, // host drives data
	input wire logic rst_n_i, // reset pin
	input wire logic hv_i, // reset pin at high voltage
	output logic [7:0] dq_o // resolved data wire
);
	logic [7:0] mem [0:131071];
	logic [16:0] wa;
	logic [7:0] last, pbyte;
	logic busy, tog, locked, id_mode, pgm, setup;
	int step, gen;
	wire rd = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
	wire wr = !ce_n_i && !we_n_i && oe_n_i && rst_n_i;

	initial
	begin
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'hff;
		mem[17'h10040] = 8'h3c;
		mem[17'h05555] = 8'h5a;
		mem[17'h02aaa] = 8'hc3;
		{busy, tog, locked, id_mode, pgm, setup, last, pbyte} = '0;
		step = 0;
		gen = 0;
	end

	// read path
	// floated wire shows the inverse of its last value, not a kind guess
	always @*
		if (host_oe_i)
			dq_o = host_dq_i;
		else if (!rd)
			dq_o = ~last;
		else if (busy)
			dq_o = {~pbyte[7], tog, 6'h00};
		else if (id_mode && addr_i == 17'h00002)
			dq_o = {7'h00, locked};
		else
			dq_o = mem[addr_i];
	always @(dq_o)
		if (rd || host_oe_i)
			last = dq_o;
	always @(negedge rd)
		if (busy)
			tog = ~tog;

	task automatic launch(input int ns);
		busy = 1'b1;
		gen++;
		fork
			begin
				automatic int g = gen;
				#(ns);
				if (g == gen)
					busy = 1'b0;
			end
		join_none
	endtask

	task automatic wipe(input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
			mem[i] = 8'hff;
		pbyte = 8'hff;
		launch(ERASE_NS);
	endtask

	task automatic do_write(input logic [16:0] a, input logic [7:0] d);
		logic ok;
		ok = !locked || hv_i;
		if (pgm)
		begin
			pgm = 1'b0;
			if (a >= 17'h04000 || ok)
				mem[a] = mem[a] & d;
			pbyte = d;
			launch(PROG_NS);
		end
		else if (step == 0 && d == 8'haa && a == 17'h05555)
			step = 1;
		else if (step == 1 && d == 8'h55 && a == 17'h02aaa)
			step = 2;
		else if (step == 2)
		begin
			step = 0;
			if (setup)
			begin
				setup = 1'b0;
				if (d == 8'h10)
					wipe(ok ? 0 : 17'h04000, 17'h1ffff);
				else if (d == 8'h40)
				begin
					locked = 1'b1;
					launch(PROG_NS);
				end
				else if (d == 8'h30 && a < 17'h04000 && ok)
					wipe(0, 17'h03fff);
				else if (d == 8'h30 && a >= 17'h04000)
					wipe(a < 17'h06000 ? 17'h04000 : a < 17'h08000 ? 17'h06000 : a < 17'h10000 ? 17'h08000 : 17'h10000,
						a < 17'h06000 ? 17'h05fff : a < 17'h08000 ? 17'h07fff : a < 17'h10000 ? 17'h0ffff : 17'h1ffff);
			end
			else
			begin
				pgm = (d == 8'ha0);
				setup = (d == 8'h80);
				id_mode = (d == 8'h90) || (id_mode && d != 8'hf0);
			end
		end
		else
		begin
			step = 0;
			if (d == 8'hf0)
				id_mode = 1'b0;
		end
	endtask

	// address at last fall, data at first rise
	always @(posedge wr)
		wa = addr_i;
	always @(negedge wr)
		if (rst_n_i && !busy)
			do_write(wa, host_dq_i);

	always @(negedge rst_n_i)
	begin
		gen++;
		{busy, pgm, setup, id_mode} = '0;
		step = 0;
	end
endmodule // pfcc_flash_model

// ---- test/parallel_flash_command_control_tb_top.sv ----
// self-checking bench for the parallel flash command controller
`timescale 1ns/1ns
module parallel_flash_command_control_tb_top;
	logic clk_sys_i, rst_n_i, en_i, cmd_valid_i, cmd_ready_o, rsp_valid_o;
	logic ce_n, oe_n, we_n, dq_oe, frst_n, hv;
	logic [16:0] addr;
	logic [7:0] dq_out, dq_in;
	pfcc_pkg::pfcc_cmd_t cmd_i;
	pfcc_pkg::pfcc_rsp_t rsp_o;
	int miscompares = 0;
	int samples_checked = 0;
	wire [7:0] err_w = {7'h00, rsp_o.err};
	wire [7:0] warn_w = {7'h00, rsp_o.warn};
	wire [7:0] lock_w = {7'h00, rsp_o.locked};

	// short poll limits keep the run brief
	pfcc_ctrl #(.BP_TIMEOUT_CYC(200), .ERASE_TIMEOUT_CYC(2000)) dut_u
	(
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .en_i(en_i), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
		.flash_addr_o(addr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
		.flash_dq_o(dq_out), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_in), .flash_rst_n_o(frst_n),
		.hv_override_o(hv)
	);
	pfcc_flash_model flash_u
	(
		.addr_i(addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .host_dq_i(dq_out),
		.host_oe_i(dq_oe), .rst_n_i(frst_n), .hv_i(hv), .dq_o(dq_in)
	);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// offer one command, hold it until taken, then wait for the answer
	task automatic run(input pfcc_pkg::pfcc_op_t op, input logic ov, input logic [16:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cmd_i = {op, ov, a, d};
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1 && n < 500)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		@(posedge clk_sys_i);
		#1;
		cmd_valid_i = 1'b0;
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (rsp_valid_o !== 1'b1)
			check(8'h00, 8'h01);
	endtask

	task automatic rd(input logic [16:0] a, input logic [7:0] e);
		run(pfcc_pkg::OP_READ, 1'b0, a, 8'h00);
		check(rsp_o.data, e);
	endtask

	task automatic t_program();
		rd(17'h10040, 8'h3c);
		run(pfcc_pkg::OP_PROGRAM, 1'b0, 17'h08010, 8'ha5);
		check(err_w, 8'h00);
		rd(17'h08010, 8'ha5);
		run(pfcc_pkg::OP_PROGRAM, 1'b0, 17'h08010, 8'hff);
		check(err_w, 8'h01);
		rd(17'h08010, 8'ha5);
	endtask

	task automatic t_erase();
		run(pfcc_pkg::OP_PROGRAM, 1'b0, 17'h04010, 8'h12);
		run(pfcc_pkg::OP_SECTOR_ERASE, 1'b0, 17'h08000, 8'h00);
		check(err_w, 8'h00);
		check(warn_w, 8'h00);
		rd(17'h08010, 8'hff);
		rd(17'h10040, 8'h3c);
		run(pfcc_pkg::OP_SECTOR_ERASE, 1'b0, 17'h06000, 8'h00);
		rd(17'h04010, 8'h12);
		run(pfcc_pkg::OP_SECTOR_ERASE, 1'b0, 17'h08000, 8'h00);
		check(warn_w, 8'h01);
		rd(17'h05555, 8'h5a);
		rd(17'h02aaa, 8'hc3);
	endtask

	task automatic t_lock();
		run(pfcc_pkg::OP_ID_ENTRY, 1'b0, 17'h00000, 8'h00);
		run(pfcc_pkg::OP_ID_EXIT, 1'b0, 17'h00000, 8'h00);
		check(err_w, 8'h00);
		run(pfcc_pkg::OP_LOCK_QUERY, 1'b0, 17'h00000, 8'h00);
		check(lock_w, 8'h00);
		run(pfcc_pkg::OP_PROGRAM, 1'b0, 17'h00100, 8'h0f);
		rd(17'h00100, 8'h0f);
		run(pfcc_pkg::OP_LOCKOUT, 1'b0, 17'h00000, 8'h00);
		run(pfcc_pkg::OP_LOCK_QUERY, 1'b0, 17'h00000, 8'h00);
		check(lock_w, 8'h01);
		run(pfcc_pkg::OP_PROGRAM, 1'b0, 17'h00101, 8'h00);
		check(err_w, 8'h01);
		rd(17'h00101, 8'hff);
		run(pfcc_pkg::OP_SECTOR_ERASE, 1'b0, 17'h00000, 8'h00);
		check(err_w, 8'h01);
		rd(17'h00100, 8'h0f);
		run(pfcc_pkg::OP_PROGRAM, 1'b1, 17'h00102, 8'h33);
		rd(17'h00102, 8'h33);
	endtask

	task automatic t_chip();
		run(pfcc_pkg::OP_CHIP_ERASE, 1'b0, 17'h00000, 8'h00);
		check(err_w, 8'h00);
		rd(17'h10040, 8'hff);
		rd(17'h00100, 8'h0f);
		run(pfcc_pkg::OP_ID_ENTRY, 1'b0, 17'h00000, 8'h00);
		run(pfcc_pkg::OP_RESET, 1'b0, 17'h00000, 8'h00);
		check(err_w, 8'h00);
		rd(17'h00002, 8'hff);
		rd(17'h04010, 8'hff);
	endtask

	// a frozen controller must hold its read strobe and still answer right
	task automatic t_freeze();
		fork
			rd(17'h10040, 8'hff);
			begin
				repeat (6) @(posedge clk_sys_i);
				#1;
				en_i = 1'b0;
				repeat (30) @(posedge clk_sys_i);
				#1;
				check({4'h0, rsp_valid_o, ce_n, oe_n, we_n}, 8'h01);
				en_i = 1'b1;
			end
		join
	endtask

	initial
	begin
		rst_n_i = 1'b0;
		en_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_i = '0;
		repeat (10) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		t_program();
		t_erase();
		t_lock();
		t_chip();
		t_freeze();
		wrap_up();
	end

	// about 40 commands of at most a few hundred cycles each
	initial
	begin
		#400000;
		miscompares++;
		wrap_up();
	end
endmodule // parallel_flash_command_control_tb_top
